// ### common/irq_pkg.sv
// Constants for the vectored interrupt logic and its return stack
package irq_pkg;

	// Widths
	localparam int ADDR_W      = 4;
	localparam int DATA_W      = 8;
	localparam int PC_W        = 16;
	localparam int DED_N       = 3;
	localparam int PER_N       = 8;
	localparam int SRC_N       = 4;
	localparam int STACK_DEPTH = 16;
	localparam int STACK_IDX_W = 4;

	// Register offsets
	localparam logic [ADDR_W-1:0] CORE_STATUS_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS  = 4'h1;
	localparam logic [ADDR_W-1:0] PER_ENABLE_OFS  = 4'h2;
	localparam logic [ADDR_W-1:0] PER_REQUEST_OFS = 4'h3;
	localparam logic [ADDR_W-1:0] EDGE_SEL_OFS    = 4'h4;

	// Field positions
	localparam int GD_BIT        = 0;
	localparam int STA_EN_LSB    = 0;
	localparam int STA_FLAG_LSB  = 4;
	localparam int SRC_EXT       = 0;
	localparam int SRC_T0OVF     = 1;
	localparam int SRC_T0CK      = 2;
	localparam int SRC_PER       = 3;
	localparam int EDGE_EXT_BIT  = 0;
	localparam int EDGE_T0CK_BIT = 1;

	// Peripheral flag positions
	localparam int PER_PORTCHG = 0;
	localparam int PER_T1OVF   = 1;
	localparam int PER_T2OVF   = 2;
	localparam int PER_T3OVF   = 3;
	localparam int PER_TXEMPTY = 4;
	localparam int PER_RXFULL  = 5;
	localparam int PER_CAP1    = 6;
	localparam int PER_CAP2    = 7;

	// Reset values
	localparam logic             GD_RST      = 1'b1;
	localparam logic [SRC_N-1:0] STA_EN_RST  = 4'h0;
	localparam logic [PER_N-1:0] PER_EN_RST  = 8'h00;
	localparam logic [1:0]       EDGE_RST    = 2'h3;

	// Vector addresses, shared peripheral vector last
	localparam logic [PC_W-1:0] VEC_EXT   = 16'h0008;
	localparam logic [PC_W-1:0] VEC_T0OVF = 16'h0010;
	localparam logic [PC_W-1:0] VEC_T0CK  = 16'h0018;
	localparam logic [PC_W-1:0] VEC_PER   = 16'h0020;

endpackage

// ### hw/irq_return_stack.sv
// Return address stack pushed on interrupt entry and popped on return
`timescale 1ns/1ps
module irq_return_stack
	import irq_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            rstn,
	input  wire logic            push,
	input  wire logic            pop,
	input  wire logic [PC_W-1:0] pushData,
	output logic      [PC_W-1:0] topData
);

	typedef struct packed {
		logic [STACK_DEPTH-1:0][PC_W-1:0] mem;
		logic [STACK_IDX_W-1:0]           idx;
	} stack_t;

	stack_t s_q;
	stack_t s_d;

	// Index points at the next free slot; wraps so a deep nest overwrites oldest
	always_comb begin
		s_d = s_q;
		if (push) begin
			s_d.mem[s_q.idx] = pushData;
			s_d.idx          = s_q.idx + STACK_IDX_W'(1);
		end else if (pop) begin
			s_d.idx = s_q.idx - STACK_IDX_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Top entry straight from the flops
	assign topData = s_q.mem[s_q.idx - STACK_IDX_W'(1)];

endmodule

// ### hw/vectored_interrupt_logic.sv
// Vectored interrupt logic: flags, masks, global disable, vectoring, return
//
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Eleven sources: pin, port, timers, serial, captures
// - Five registers hold interrupt control and status
// - Global disable bit blocks every response
// - Response sets disable, pushes return, loads vector
// - Four vectors; peripherals share the last
// - Dedicated vector clears its own flag
// - Peripheral vector leaves peripheral flags alone
// - Flags set regardless of masks and disable
// - Two-cycle instruction adds one cycle latency
// - Return pops stack and clears disable
module vectored_interrupt_logic
	import irq_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [DATA_W-1:0] regWdata,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [DATA_W-1:0] regRdata,
	input  wire logic              externalIrqPin,
	input  wire logic              timerZeroClockPin,
	input  wire logic              portChangeEvent,
	input  wire logic              timerZeroOvf,
	input  wire logic              timerOneOvf,
	input  wire logic              timerTwoOvf,
	input  wire logic              timerThreeOvf,
	input  wire logic              txBufEmpty,
	input  wire logic              rxBufFull,
	input  wire logic              capture1Event,
	input  wire logic              capture2Event,
	input  wire logic              instrBoundary,
	input  wire logic              returnFromIrqInstr,
	input  wire logic [PC_W-1:0]   returnAddr,
	output logic                   pcLoad,
	output logic      [PC_W-1:0]   pcLoadValue,
	output logic                   vectorTake,
	output logic                   irqOut
);

	typedef struct packed {
		logic              globalIrqDisable;
		logic [SRC_N-1:0]  srcEnable;
		logic [DED_N-1:0]  dedFlag;
		logic [PER_N-1:0]  perEnable;
		logic [PER_N-1:0]  perFlag;
		logic [1:0]        edgeRising;
		logic              extPinPrev;
		logic              t0ckPinPrev;
		logic [DATA_W-1:0] rdata;
		logic              pcLoad;
		logic [PC_W-1:0]   pcValue;
		logic              vectorTake;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic [PC_W-1:0]  stackTop;
	logic             take;
	logic             retTake;
	logic [SRC_N-1:0] req;
	logic [SRC_N-1:0] sel;
	logic [DED_N-1:0] dedEvent;
	logic [PER_N-1:0] perEvent;
	logic             extEvent;
	logic             t0ckEvent;

	// Lowest index wins: pin, overflow, clock edge, peripherals
	function automatic logic [SRC_N-1:0] pickSource(input logic [SRC_N-1:0] r);
		logic [SRC_N-1:0] one;
		one = '0;
		for (int i = SRC_N - 1; i >= 0; i--) begin
			if (r[i]) begin
				one = '0;
				one[i] = 1'b1;
			end
		end
		return one;
	endfunction

	// One vector address per one-hot source choice
	function automatic logic [PC_W-1:0] vectorOf(input logic [SRC_N-1:0] s);
		logic [PC_W-1:0] v;
		v = VEC_PER;
		if (s[SRC_EXT]) begin
			v = VEC_EXT;
		end else if (s[SRC_T0OVF]) begin
			v = VEC_T0OVF;
		end else if (s[SRC_T0CK]) begin
			v = VEC_T0CK;
		end
		return v;
	endfunction

	// Pin edges in the direction software selects
	assign extEvent  = s_q.edgeRising[EDGE_EXT_BIT] ? (externalIrqPin & ~s_q.extPinPrev)
	                                                : (~externalIrqPin & s_q.extPinPrev);
	assign t0ckEvent = s_q.edgeRising[EDGE_T0CK_BIT] ? (timerZeroClockPin & ~s_q.t0ckPinPrev)
	                                                 : (~timerZeroClockPin & s_q.t0ckPinPrev);

	// All eleven sources gathered into flag-shaped vectors
	always_comb begin
		dedEvent             = '0;
		dedEvent[SRC_EXT]    = extEvent;
		dedEvent[SRC_T0OVF]  = timerZeroOvf;
		dedEvent[SRC_T0CK]   = t0ckEvent;
		perEvent             = '0;
		perEvent[PER_PORTCHG] = portChangeEvent;
		perEvent[PER_T1OVF]  = timerOneOvf;
		perEvent[PER_T2OVF]  = timerTwoOvf;
		perEvent[PER_T3OVF]  = timerThreeOvf;
		perEvent[PER_TXEMPTY] = txBufEmpty;
		perEvent[PER_RXFULL] = rxBufFull;
		perEvent[PER_CAP1]   = capture1Event;
		perEvent[PER_CAP2]   = capture2Event;
	end

	// Requests: flag and enable; peripherals summed behind their own enable
	always_comb begin
		req = '0;
		req[DED_N-1:0] = s_q.dedFlag & s_q.srcEnable[DED_N-1:0];
		req[SRC_PER]   = (|(s_q.perFlag & s_q.perEnable)) & s_q.srcEnable[SRC_PER];
	end

	assign sel = pickSource(req);

	// Only at an instruction edge, so a two-cycle instruction delays entry
	assign retTake = returnFromIrqInstr;
	assign take    = instrBoundary & ~s_q.globalIrqDisable & (|req) & ~retTake;

	// Next state of every register
	always_comb begin
		logic [DED_N-1:0] dedClr;
		logic [PER_N-1:0] perClr;
		dedClr = '0;
		perClr = '0;
		s_d = s_q;
		s_d.pcLoad      = 1'b0;
		s_d.vectorTake  = 1'b0;
		s_d.extPinPrev  = externalIrqPin;
		s_d.t0ckPinPrev = timerZeroClockPin;

		// Software writes; flag bits clear on a written one
		if (regWr) begin
			case (regAddr)
				CORE_STATUS_OFS: begin
					s_d.globalIrqDisable = regWdata[GD_BIT];
				end
				IRQ_STATUS_OFS: begin
					s_d.srcEnable = regWdata[STA_EN_LSB +: SRC_N];
					dedClr        = regWdata[STA_FLAG_LSB +: DED_N];
				end
				PER_ENABLE_OFS: begin
					s_d.perEnable = regWdata;
				end
				PER_REQUEST_OFS: begin
					perClr = regWdata;
				end
				EDGE_SEL_OFS: begin
					s_d.edgeRising = regWdata[1:0];
				end
				default: begin
				end
			endcase
		end

		// Dedicated flag cleared by its own vector; peripheral flags kept
		if (take) begin
			dedClr = dedClr | sel[DED_N-1:0];
		end

		// New events win over any clear in the same cycle
		s_d.dedFlag = (s_q.dedFlag & ~dedClr) | dedEvent;
		s_d.perFlag = (s_q.perFlag & ~perClr) | perEvent;

		// Entry: disable further response and jump to the chosen vector
		if (take) begin
			s_d.globalIrqDisable = 1'b1;
			s_d.pcLoad           = 1'b1;
			s_d.vectorTake       = 1'b1;
			s_d.pcValue          = vectorOf(sel);
		end

		// Return: popped address and responses allowed again
		if (retTake) begin
			s_d.globalIrqDisable = 1'b0;
			s_d.pcLoad           = 1'b1;
			s_d.pcValue          = stackTop;
		end

		// Read data stands one cycle after the strobe only
		s_d.rdata = '0;
		if (regRd) begin
			case (regAddr)
				CORE_STATUS_OFS: begin
					s_d.rdata[GD_BIT] = s_q.globalIrqDisable;
				end
				IRQ_STATUS_OFS: begin
					s_d.rdata[STA_EN_LSB +: SRC_N]   = s_q.srcEnable;
					s_d.rdata[STA_FLAG_LSB +: DED_N] = s_q.dedFlag;
					s_d.rdata[STA_FLAG_LSB + SRC_PER] = |(s_q.perFlag & s_q.perEnable);
				end
				PER_ENABLE_OFS: begin
					s_d.rdata = s_q.perEnable;
				end
				PER_REQUEST_OFS: begin
					s_d.rdata = s_q.perFlag;
				end
				EDGE_SEL_OFS: begin
					s_d.rdata[1:0] = s_q.edgeRising;
				end
				default: begin
				end
			endcase
		end
	end

	// Single register stage for all state
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_q                  <= '0;
			s_q.globalIrqDisable <= GD_RST;
			s_q.srcEnable        <= STA_EN_RST;
			s_q.perEnable        <= PER_EN_RST;
			s_q.edgeRising       <= EDGE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Return addresses live in their own small stack
	irq_return_stack u_stack (
		.clk      (clk),
		.rstn     (rstn),
		.push     (take),
		.pop      (retTake),
		.pushData (returnAddr),
		.topData  (stackTop)
	);

	// Outputs from flops, except the level line, which is combinational from the requests and ignores the global disable
	assign regRdata    = s_q.rdata;
	assign pcLoad      = s_q.pcLoad;
	assign pcLoadValue = s_q.pcValue;
	assign vectorTake  = s_q.vectorTake;
	assign irqOut      = |req;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence entryCause;
		instrBoundary && !s_q.globalIrqDisable && (|req) && !returnFromIrqInstr;
	endsequence

	sequence entryDone;
		vectorTake && pcLoad && s_q.globalIrqDisable;
	endsequence

	sequence returnDone;
		pcLoad && !vectorTake && !s_q.globalIrqDisable;
	endsequence

	chk_disable_blocks: assert property (
		s_q.globalIrqDisable |=> !vectorTake)
		else $error("vector taken while globally disabled");

	chk_entry_sequence: assert property (
		entryCause |=> entryDone)
		else $error("entry did not set disable and load vector");

	chk_request_gate: assert property (
		(instrBoundary && !returnFromIrqInstr && (|req) && !s_q.globalIrqDisable)
		|-> ##1 vectorTake)
		else $error("pending enabled request not vectored");

	chk_ext_priority: assert property (
		entryCause and req[SRC_EXT] |=> pcLoadValue == VEC_EXT)
		else $error("external pin lost priority");

	chk_periph_vector: assert property (
		entryCause and (req[DED_N-1:0] == '0) |=> pcLoadValue == VEC_PER)
		else $error("peripheral request went to wrong vector");

	chk_ded_clear: assert property (
		entryCause and req[SRC_T0OVF] && !req[SRC_EXT] && !timerZeroOvf
		|=> !s_q.dedFlag[SRC_T0OVF])
		else $error("dedicated flag not cleared on entry");

	chk_periph_kept: assert property (
		(entryCause and !regWr) |=> ($past(s_q.perFlag) & ~s_q.perFlag) == '0)
		else $error("peripheral flag cleared by vectoring");

	chk_flag_sets: assert property (
		capture2Event |=> s_q.perFlag[PER_CAP2])
		else $error("event flag not set");

	chk_boundary_only: assert property (
		!instrBoundary |=> !vectorTake)
		else $error("vector taken off an instruction boundary");

	// A pending request may re-enter at once, so only a second pop is barred
	chk_return_pop: assert property (
		returnFromIrqInstr ##1 !returnFromIrqInstr
		|-> (returnDone and pcLoadValue == $past(stackTop)) ##1 (!pcLoad || vectorTake))
		else $error("return did not pop and re-enable");

endmodule

// ### verification/core_model.sv
// Behavioural core sequencer facing the interrupt block
`timescale 1ns/1ps
module core_model
	import irq_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            rstn,
	input  wire logic            slow,
	input  wire logic            retReq,
	input  wire logic            pcLoad,
	input  wire logic [PC_W-1:0] pcLoadValue,
	input  wire logic            vectorTake,
	output logic                 instrBoundary,
	output logic                 returnFromIrqInstr,
	output logic      [PC_W-1:0] returnAddr,
	output logic      [7:0]      entries,
	output logic      [7:0]      retErr,
	output logic      [PC_W-1:0] lastVec
);
	logic [PC_W-1:0] stack [$];
	logic [PC_W-1:0] prevAddr;

	// Program flow; slow mode models two-cycle instructions
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			instrBoundary <= 1'b0;
			returnFromIrqInstr <= 1'b0;
			returnAddr <= 16'h0100;
			entries <= 8'h00;
			retErr <= 8'h00;
			lastVec <= 16'h0000;
			prevAddr <= 16'h0000;
		end else begin
			instrBoundary <= slow ? !instrBoundary : 1'b1;
			returnFromIrqInstr <= retReq;
			// Address as sampled at the entry edge
			prevAddr <= returnAddr;
			if (pcLoad)
				returnAddr <= pcLoadValue;
			else if (instrBoundary)
				returnAddr <= returnAddr + 16'h0001;
			if (vectorTake) begin
				entries <= entries + 8'h01;
				lastVec <= pcLoadValue;
				stack.push_back(prevAddr);
			end else if (pcLoad && (stack.size() == 0 || pcLoadValue !== stack.pop_back()))
				retErr <= retErr + 8'h01;
		end
	end
endmodule

// ### verification/vectored_interrupt_logic_bench.sv
// Self-checking bench for the vectored interrupt logic
`timescale 1ns/1ps
module vectored_interrupt_logic_bench
	import irq_pkg::*;
();
	logic              clk = 1'b0;
	logic              rstn = 1'b0;
	logic [ADDR_W-1:0] regAddr = 4'h0;
	logic [DATA_W-1:0] regWdata = 8'h00;
	logic [DATA_W-1:0] regRdata;
	logic              regWr = 1'b0;
	logic              regRd = 1'b0;
	logic              extPin = 1'b0;
	logic              t0Pin = 1'b0;
	logic              slow = 1'b0;
	logic              retReq = 1'b0;
	logic [8:0]        ev = 9'h000;
	logic              instrBoundary;
	logic              retInstr;
	logic              pcLoad;
	logic              vectorTake;
	logic              irqOut;
	logic [PC_W-1:0]   retAddr;
	logic [PC_W-1:0]   pcLoadValue;
	logic [PC_W-1:0]   lastVec;
	logic [7:0]        entries;
	logic [7:0]        retErr;
	int                fails = 0;
	int                nTests = 0;
	int                cyc = 0;

	always #20 clk = ~clk;

	vectored_interrupt_logic DUT (.clk(clk), .rstn(rstn), .regAddr(regAddr),
		.regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
		.externalIrqPin(extPin), .timerZeroClockPin(t0Pin), .portChangeEvent(ev[0]),
		.timerZeroOvf(ev[1]), .timerOneOvf(ev[2]), .timerTwoOvf(ev[3]),
		.timerThreeOvf(ev[4]), .txBufEmpty(ev[5]), .rxBufFull(ev[6]),
		.capture1Event(ev[7]), .capture2Event(ev[8]), .instrBoundary(instrBoundary),
		.returnFromIrqInstr(retInstr), .returnAddr(retAddr), .pcLoad(pcLoad),
		.pcLoadValue(pcLoadValue), .vectorTake(vectorTake), .irqOut(irqOut));

	core_model core (.clk(clk), .rstn(rstn), .slow(slow), .retReq(retReq),
		.pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .vectorTake(vectorTake),
		.instrBoundary(instrBoundary), .returnFromIrqInstr(retInstr),
		.returnAddr(retAddr), .entries(entries), .retErr(retErr), .lastVec(lastVec));

	task automatic end_sim();
		$display("counts: %0d checks, %0d fails", nTests, fails);
		if (fails == 0 && nTests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
		nTests++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(logic [3:0] a, logic [15:0] exp);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		#1 cmp("regRdata", exp, {8'h00, regRdata});
	endtask

	task automatic pulse(logic [8:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 9'h000;
	endtask

	// Bounded wait on the model's entry count, then the vector seen
	task automatic entry(logic [7:0] n, logic [15:0] vec);
		int k;
		k = 0;
		while (entries !== n && k < 30) begin
			@(posedge clk);
			k++;
		end
		cmp("entries", {8'h00, n}, {8'h00, entries});
		cmp("vector", vec, lastVec);
	endtask

	task automatic ret();
		@(posedge clk);
		retReq <= 1'b1;
		@(posedge clk);
		retReq <= 1'b0;
		repeat (4) @(posedge clk);
	endtask

	task automatic t_reset();
		rd(CORE_STATUS_OFS, 16'h0001);
		rd(IRQ_STATUS_OFS, 16'h0000);
		rd(PER_ENABLE_OFS, 16'h0000);
		rd(PER_REQUEST_OFS, 16'h0000);
		rd(EDGE_SEL_OFS, 16'h0003);
		rd(4'h5, 16'h0000);
		$display("test reset done");
	endtask

	// Every source latches while masked and globally disabled
	task automatic t_flags();
		pulse(9'h1FF);
		@(posedge clk);
		extPin <= 1'b1;
		t0Pin <= 1'b1;
		rd(PER_REQUEST_OFS, 16'h00FF);
		rd(IRQ_STATUS_OFS, 16'h0070);
		wr(IRQ_STATUS_OFS, 8'h0F);
		wr(PER_ENABLE_OFS, 8'hFF);
		rd(IRQ_STATUS_OFS, 16'h00FF);
		repeat (10) @(posedge clk);
		cmp("entries", 16'h0000, {8'h00, entries});
		cmp("irqOut", 16'h0001, {15'h0000, irqOut});
		$display("test flags done");
	endtask

	// All four pending: served one by one in fixed order
	task automatic t_prio();
		wr(CORE_STATUS_OFS, 8'h00);
		entry(8'h01, VEC_EXT);
		rd(CORE_STATUS_OFS, 16'h0001);
		rd(IRQ_STATUS_OFS, 16'h00EF);
		ret();
		entry(8'h02, VEC_T0OVF);
		rd(IRQ_STATUS_OFS, 16'h00CF);
		ret();
		entry(8'h03, VEC_T0CK);
		ret();
		entry(8'h04, VEC_PER);
		rd(PER_REQUEST_OFS, 16'h00FF);
		wr(PER_REQUEST_OFS, 8'hFF);
		ret();
		repeat (10) @(posedge clk);
		cmp("entries", 16'h0004, {8'h00, entries});
		rd(CORE_STATUS_OFS, 16'h0000);
		cmp("retErr", 16'h0000, {8'h00, retErr});
		$display("test priority done");
	endtask

	// Peripheral flag without its enable stays quiet; slow core still served
	task automatic t_mask();
		wr(PER_ENABLE_OFS, 8'hFE);
		pulse(9'h001);
		repeat (10) @(posedge clk);
		cmp("entries", 16'h0004, {8'h00, entries});
		cmp("irqOut", 16'h0000, {15'h0000, irqOut});
		slow <= 1'b1;
		wr(PER_ENABLE_OFS, 8'h01);
		entry(8'h05, VEC_PER);
		wr(PER_REQUEST_OFS, 8'h01);
		ret();
		cmp("retErr", 16'h0000, {8'h00, retErr});
		$display("test mask done");
	endtask

	// Falling-edge selection on both pins, then served in fixed order
	task automatic t_edge();
		wr(EDGE_SEL_OFS, 8'h00);
		rd(EDGE_SEL_OFS, 16'h0000);
		@(posedge clk);
		extPin <= 1'b0;
		t0Pin <= 1'b0;
		entry(8'h06, VEC_EXT);
		ret();
		entry(8'h07, VEC_T0CK);
		ret();
		rd(IRQ_STATUS_OFS, 16'h000F);
		cmp("retErr", 16'h0000, {8'h00, retErr});
		$display("test edge done");
	endtask

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			end_sim();
		end
	end

	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_flags();
		t_prio();
		t_mask();
		t_edge();
		end_sim();
	end
endmodule
